// ==== rtl/lpmcc_top.sv ====
// low-power mode sequencer and system clock controller with a wishbone slave
//
// Implementation choices: the address map and the Wishbone interface to the registers.
`include "lpmcc_map.svh"
`default_nettype none
module lpmcc_top #(
   parameter int STOP_WAKE_CYC = `LPMCC_STOP_WAKE_CYC,
   parameter int STBY_WAKE_CYC = `LPMCC_STBY_WAKE_CYC,
   parameter int LSE_TMO       = `LPMCC_LSE_TMO,
   parameter int GPIO_W        = 16
) (
   input  wire logic                sys_clk,
   input  wire logic                external_reset_pin,
   // wishbone slave
   input  wire logic                wb_cyc_i,
   input  wire logic                wb_stb_i,
   input  wire logic                wb_we_i,
   input  wire logic [7:0]          wb_adr_i,
   input  wire logic [3:0]          wb_sel_i,
   input  wire logic [31:0]         wb_dat_i,
   output logic      [31:0]         wb_dat_o,
   output logic                     wb_ack_o,
   // wake sources from pins and peripherals
   input  wire logic [GPIO_W-1:0]   gpio_line,
   input  wire logic                supply_voltage_detector,
   input  wire logic [1:0]          comp_event,
   input  wire logic                vref_on,
   input  wire logic [4:0]          periph_wake,
   input  wire logic                periph_osc_req,
   input  wire logic                external_reset_pin_n,
   input  wire logic                watchdog_reset,
   input  wire logic [2:0]          wakeup_pin,
   input  wire logic [4:0]          rtc_event,
   // oscillator activity, toggling levels
   input  wire logic                hse_tick,
   input  wire logic                lse_tick,
   // clock and power controls
   output lpmcc_pkg::lpmcc_src_t    master_src,
   output logic                     clocks_gated,
   output logic                     pll_en,
   output logic                     msi_en,
   output logic                     hsi_en,
   output logic                     hse_en,
   output logic                     lse_en,
   output logic                     lsi_en,
   output logic                     core_power_on,
   output logic                     core_reset_n,
   output logic                     cpu_wake,
   output logic                     sys_bus_en,
   output logic                     periph1_en,
   output logic                     periph2_en,
   output logic [1:0]               clock_output_sel,
   output logic                     irq
);
   import lpmcc_pkg::*;

   // ----------------------------------------------------------------
   // input synchronisers
   // ----------------------------------------------------------------
   localparam int SW = GPIO_W + 1 + 2 + 1 + 5 + 1 + 1 + 3 + 5 + 2;
   logic [SW-1:0] sync1;
   logic [SW-1:0] sync2;
   always_ff @(posedge sys_clk or negedge external_reset_pin) begin
      if (!external_reset_pin) begin
         sync1 <= '0;
         sync2 <= '0;
      end else begin
         sync1 <= {gpio_line, supply_voltage_detector, comp_event, vref_on, periph_wake,
                   periph_osc_req, ~external_reset_pin_n, wakeup_pin, rtc_event,
                   hse_tick, lse_tick};
         sync2 <= sync1;
      end
   end
   wire [GPIO_W-1:0] s_gpio = sync2[SW-1 -: GPIO_W];
   wire       s_pvd      = sync2[20];
   wire [1:0] s_comp     = sync2[19:18];
   wire       s_vref     = sync2[17];
   wire [4:0] s_periph   = sync2[16:12];
   wire       s_osc_req  = sync2[11];
   wire       s_xrst     = sync2[10];
   wire [2:0] s_wkp      = sync2[9:7];
   wire [4:0] s_rtc      = sync2[6:2];
   wire       s_hse      = sync2[1];
   wire       s_lse      = sync2[0];
   logic       s_wdg;
   // watchdog reset is same-domain logic: no sync
   assign s_wdg = watchdog_reset;

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   logic [8:0]  ctrl;
   logic [31:0] clk_cfg;
   logic [`LPMCC_IRQ_W-1:0] irq_stat;
   logic [`LPMCC_IRQ_W-1:0] irq_mask;
   logic [7:0]  retain;          // standby-domain scratch, survives standby
   logic [2:0]  wkp_q;
   logic        hse_q;
   logic        lse_q;
   logic [4:0]  hse_cnt;
   logic [12:0] lse_cnt;
   logic        hse_failed;
   logic        core_lost;
   logic        lse_wake;
   logic [17:0] wake_cnt;
   lpmcc_state_t state;
   lpmcc_state_t next_state;

   // bus decode
   wire wb_req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire wb_wr    = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i & wb_sel_i[0];  // lands with ack
   wire sel_ctrl = wb_adr_i == `LPMCC_CTRL_OFS;
   wire sel_stat = wb_adr_i == `LPMCC_STATUS_OFS;
   wire sel_irq  = wb_adr_i == `LPMCC_IRQ_OFS;
   wire sel_mask = wb_adr_i == `LPMCC_MASK_OFS;
   wire sel_clk  = wb_adr_i == `LPMCC_CLK_OFS;
   wire sel_ret  = wb_adr_i == `LPMCC_RETAIN_OFS;

   // ----------------------------------------------------------------
   // wake source qualification
   // ----------------------------------------------------------------
   // stop wake sources
   wire stop_wake = (|s_gpio) | s_pvd | ((|s_comp) & s_vref) | (|s_periph) | lse_wake;
   wire [2:0] wkp_rise = s_wkp & ~wkp_q & ctrl[`LPMCC_CTRL_WKP_EN];
   wire rtc_mode = ctrl[`LPMCC_CTRL_RTC];
   // without rtc only reset pin and wake pins
   wire stby_wake = s_xrst | (|wkp_rise) | (rtc_mode & (s_wdg | (|s_rtc)));
   assign lse_wake = irq_stat[`LPMCC_IRQ_LSEFAIL] & irq_mask[`LPMCC_IRQ_LSEFAIL];

   // ----------------------------------------------------------------
   // mode sequencer
   // ----------------------------------------------------------------
   always_comb begin
      next_state = state;
      case (state)
         LPMCC_RUN: begin
            if (ctrl[`LPMCC_CTRL_STBY]) begin
               next_state = LPMCC_STBY;
            end else if (ctrl[`LPMCC_CTRL_STOP]) begin
               next_state = LPMCC_STOP;
            end
         end
         LPMCC_STOP: begin
            if (stop_wake) begin
               next_state = LPMCC_RUN;
            end
         end
         LPMCC_STBY: begin
            if (stby_wake) begin
               next_state = LPMCC_WAKE;
            end
         end
         LPMCC_WAKE: begin
            if (wake_cnt == 18'(STBY_WAKE_CYC - 1)) begin
               next_state = LPMCC_RUN;
            end
         end
         default: next_state = LPMCC_RUN;
      endcase
   end

   // state and wake latency counter, WAKE held for STBY_WAKE_CYC cycles before RUN
   always_ff @(posedge sys_clk or negedge external_reset_pin) begin
      if (!external_reset_pin) begin
         state    <= LPMCC_RUN;
         wake_cnt <= '0;
      end else begin
         state    <= next_state;
         wake_cnt <= (state == LPMCC_WAKE) ? wake_cnt + 18'h1 : '0;
      end
   end

   // edge history for wake pins and oscillator ticks
   always_ff @(posedge sys_clk or negedge external_reset_pin) begin
      if (!external_reset_pin) begin
         wkp_q <= '0;
         hse_q <= 1'b0;
         lse_q <= 1'b0;
      end else begin
         wkp_q <= s_wkp;
         hse_q <= s_hse;
         lse_q <= s_lse;
      end
   end

   // ----------------------------------------------------------------
   // clock failure monitors: count cycles without an edge
   // ----------------------------------------------------------------
   wire hse_on   = clk_cfg[`LPMCC_CLK_SRC] == 2'(LPMCC_SRC_HSE) & ~hse_failed;
   wire hse_dead = hse_cnt == 5'(`LPMCC_HSE_TMO);
   wire lse_dead = lse_cnt == 13'(LSE_TMO);
   always_ff @(posedge sys_clk or negedge external_reset_pin) begin
      if (!external_reset_pin) begin
         hse_cnt <= '0;
         lse_cnt <= '0;
      end else begin
         hse_cnt <= (s_hse ^ hse_q) | ~ctrl[`LPMCC_CTRL_CSS_EN] | hse_dead ? '0 : hse_cnt + 5'h1;
         lse_cnt <= (s_lse ^ lse_q) | ~ctrl[`LPMCC_CTRL_LCSS_EN] | lse_dead ? '0
                    : lse_cnt + 13'h1;
      end
   end

   // fall back to internal oscillator on failure
   always_ff @(posedge sys_clk or negedge external_reset_pin) begin
      if (!external_reset_pin) begin
         hse_failed <= 1'b0;
      end else if (hse_dead & hse_on) begin
         hse_failed <= 1'b1;
      end else if ((wb_wr & sel_clk) | (state == LPMCC_WAKE)) begin
         hse_failed <= 1'b0;   // new source, or restart on the multispeed oscillator
      end
   end

   // ----------------------------------------------------------------
   // register writes
   // ----------------------------------------------------------------
   wire [`LPMCC_IRQ_W-1:0] irq_set = {lse_dead, hse_dead & hse_on,
                                      state == LPMCC_STOP & stop_wake};
   wire core_clr = state == LPMCC_WAKE;
   always_ff @(posedge sys_clk or negedge external_reset_pin) begin
      if (!external_reset_pin) begin
         ctrl     <= '0;
         clk_cfg  <= `LPMCC_CLK_RST;
         irq_mask <= '0;
      end else if (core_clr) begin
         // lose core-domain registers; rtc, monitor and wake enables kept
         ctrl     <= {1'b0, ctrl[7:2], 2'b00};
         clk_cfg  <= `LPMCC_CLK_RST;
         irq_mask <= '0;
      end else begin
         if (wb_wr & sel_ctrl) begin
            ctrl <= wb_dat_i[8:0];
         end else if (state == LPMCC_STOP & stop_wake) begin
            ctrl[`LPMCC_CTRL_STOP] <= 1'b0;
         end
         if (wb_wr & sel_clk) begin
            clk_cfg <= {19'h0, wb_dat_i[12:0]};
         end
         if (wb_wr & sel_mask) begin
            irq_mask <= wb_dat_i[`LPMCC_IRQ_W-1:0];
         end
      end
   end

   // sticky status: set wins over write-one-to-clear
   always_ff @(posedge sys_clk or negedge external_reset_pin) begin
      if (!external_reset_pin) begin
         irq_stat <= '0;
         retain   <= '0;
      end else begin
         irq_stat <= irq_set | (irq_stat & ~((wb_wr & sel_irq) ? wb_dat_i[`LPMCC_IRQ_W-1:0] : '0));
         if (wb_wr & sel_ret) begin
            retain <= wb_dat_i[7:0];
         end
      end
   end

   // core-lost flag, readable after standby exit
   always_ff @(posedge sys_clk or negedge external_reset_pin) begin
      if (!external_reset_pin) begin
         core_lost <= 1'b0;
      end else if (core_clr) begin
         core_lost <= 1'b1;
      end else if (wb_wr & sel_stat) begin
         core_lost <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // bus prescalers: divide-by-(n+1) enable pulses
   // ----------------------------------------------------------------
   logic [2:0] div_cnt [3];
   logic [2:0] div_en;
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_div
         wire [2:0] lim = clk_cfg[4 + gi*3 +: 3];
         always_ff @(posedge sys_clk or negedge external_reset_pin) begin
            if (!external_reset_pin) begin
               div_cnt[gi] <= '0;
               div_en[gi]  <= 1'b0;
            end else begin
               div_cnt[gi] <= (div_cnt[gi] >= lim) ? '0 : div_cnt[gi] + 3'h1;
               div_en[gi]  <= (div_cnt[gi] >= lim) & ~clocks_gated;
            end
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   wire in_stop = state == LPMCC_STOP;
   wire in_stby = state == LPMCC_STBY;
   assign clocks_gated  = in_stop | in_stby;
   assign pll_en        = ~clocks_gated & clk_cfg[`LPMCC_CLK_SRC] == 2'(LPMCC_SRC_PLL);
   assign msi_en        = ~clocks_gated;
   // waking peripheral may keep internal oscillator
   assign hsi_en        = (~clocks_gated & (master_src == LPMCC_SRC_HSI))
                          | (in_stop & s_osc_req);
   assign hse_en        = ~clocks_gated & hse_on;
   // low-speed oscillators run in standby with rtc
   // rtc clock stopped by stop entry unless rtc mode is set
   assign lse_en        = ~(in_stby & ~rtc_mode) & ~(in_stop & ~rtc_mode);
   assign lsi_en        = lse_en;
   assign core_power_on = ~in_stby;
   assign core_reset_n  = ~(in_stby | core_clr);
   assign cpu_wake      = in_stop & stop_wake;
   assign master_src    = hse_failed ? LPMCC_SRC_HSI : lpmcc_src_t'(clk_cfg[`LPMCC_CLK_SRC]);
   assign sys_bus_en    = div_en[0];
   assign periph1_en    = div_en[1];
   assign periph2_en    = div_en[2];
   assign clock_output_sel = clk_cfg[`LPMCC_CLK_OUT];
   assign irq           = |(irq_stat & irq_mask);

   // read mux; unmapped addresses read zero and still ack
   wire [31:0] rd_mux = sel_ctrl ? {23'h0, ctrl}
                      : sel_stat ? {26'h0, core_lost, hse_failed, 2'(state), 2'(master_src)}
                      : sel_irq  ? {29'h0, irq_stat}
                      : sel_mask ? {29'h0, irq_mask}
                      : sel_clk  ? clk_cfg
                      : sel_ret  ? {24'h0, retain}
                      : 32'h0;
   always_ff @(posedge sys_clk or negedge external_reset_pin) begin
      if (!external_reset_pin) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= '0;
      end else begin
         wb_ack_o <= wb_req;
         wb_dat_o <= wb_req ? rd_mux : wb_dat_o;
      end
   end

endmodule : lpmcc_top
`default_nettype wire

// ==== rtl/lpmcc_map.svh ====
// register offsets, field positions, reset values and timing counts of the power/clock controller
`ifndef LPMCC_MAP_SVH
`define LPMCC_MAP_SVH
// register byte offsets
`define LPMCC_CTRL_OFS      8'h00
`define LPMCC_STATUS_OFS    8'h04
`define LPMCC_IRQ_OFS       8'h08
`define LPMCC_MASK_OFS      8'h0C
`define LPMCC_CLK_OFS       8'h10
`define LPMCC_RETAIN_OFS    8'h14
// control fields
`define LPMCC_CTRL_STOP     0
`define LPMCC_CTRL_STBY     1
`define LPMCC_CTRL_RTC      2
`define LPMCC_CTRL_CSS_EN   3
`define LPMCC_CTRL_LCSS_EN  4
`define LPMCC_CTRL_WKP_EN   7:5
`define LPMCC_CTRL_PER_OSC  8
// clock config fields
`define LPMCC_CLK_SRC       1:0
`define LPMCC_CLK_OUT       3:2
`define LPMCC_CLK_SYSDIV    6:4
`define LPMCC_CLK_P1DIV     9:7
`define LPMCC_CLK_P2DIV     12:10
`define LPMCC_CLK_RST       32'h0000_0000
// interrupt status bits
`define LPMCC_IRQ_STOPWK    0
`define LPMCC_IRQ_HSEFAIL   1
`define LPMCC_IRQ_LSEFAIL   2
`define LPMCC_IRQ_W         3
// timing: wake latencies in nanoseconds
`define LPMCC_CLK_MHZ       250
`define LPMCC_STOP_WAKE_NS  3500
`define LPMCC_STBY_WAKE_NS  60000
`define LPMCC_STOP_WAKE_CYC ((`LPMCC_STOP_WAKE_NS * `LPMCC_CLK_MHZ) / 1000)
`define LPMCC_STBY_WAKE_CYC ((`LPMCC_STBY_WAKE_NS * `LPMCC_CLK_MHZ) / 1000)
// oscillator failure: no edge of the monitored clock within this many cycles
`define LPMCC_HSE_TMO       16
`define LPMCC_LSE_TMO       4096
`endif

// ==== rtl/lpmcc_pkg.sv ====
// types of the power/clock controller
`default_nettype none
package lpmcc_pkg;
   typedef enum logic [1:0] {LPMCC_SRC_MSI, LPMCC_SRC_HSI, LPMCC_SRC_HSE, LPMCC_SRC_PLL} lpmcc_src_t;
   typedef enum {LPMCC_RUN, LPMCC_STOP, LPMCC_STBY, LPMCC_WAKE} lpmcc_state_t;
endpackage : lpmcc_pkg
`default_nettype wire

// ==== tb/lpmcc_checker_properties.sv ====
// port-level assertions of the power/clock controller
`default_nettype none
module lpmcc_checker
#(
   parameter int GPIO_W = 16
) (
   input wire logic                  sys_clk,
   input wire logic                  external_reset_pin,
   input wire logic                  wb_cyc_i,
   input wire logic                  wb_stb_i,
   input wire logic                  wb_ack_o,
   input wire logic [GPIO_W-1:0]     gpio_line,
   input wire logic                  external_reset_pin_n,
   input wire lpmcc_pkg::lpmcc_src_t master_src,
   input wire logic                  clocks_gated,
   input wire logic                  pll_en,
   input wire logic                  msi_en,
   input wire logic                  hsi_en,
   input wire logic                  hse_en,
   input wire logic                  core_power_on,
   input wire logic                  core_reset_n,
   input wire logic                  sys_bus_en
);
   timeunit 1ns;
   timeprecision 1ps;
   import lpmcc_pkg::*;
   // ----------------------------------------
   // helper: cycles since a reset-pin wake
   // ----------------------------------------
   localparam int STBY_MAX = 15000;
   logic        pend;
   logic [15:0] wk_cnt;
   // pending until the core is powered and out of reset again
   wire         run_again = core_reset_n && core_power_on;
   wire         next_pend = (pend || (!external_reset_pin_n && !core_power_on)) && !run_again;
   always_ff @(posedge sys_clk or negedge external_reset_pin) begin
      if (!external_reset_pin) begin
         pend   <= 1'b0;
         wk_cnt <= 16'h0000;
      end else begin
         pend   <= next_pend;
         wk_cnt <= pend ? wk_cnt + 16'h0001 : 16'h0000;
      end
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!external_reset_pin);
   AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack stood longer than one cycle");
   AST_ACK_REQ: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("request not acknowledged next cycle");
   AST_STOP_OSC: assert property (clocks_gated && core_power_on |-> !(pll_en | hse_en | msi_en))
      else $error("oscillator running in stop");
   AST_STBY_OSC: assert property (!core_power_on |-> !(pll_en | msi_en | hsi_en | hse_en))
      else $error("fast oscillator running with core off");
   AST_BUS_GATED: assert property (clocks_gated && $past(clocks_gated) |-> !sys_bus_en)
      else $error("bus enable while clocks gated");
   AST_STOP_WAKE: assert property ($rose(|gpio_line) && clocks_gated && core_power_on
      |-> ##[1:875] !clocks_gated)
      else $error("stop not left within 3.5 us");
   AST_STBY_EXIT: assert property (int'(wk_cnt) <= STBY_MAX)
      else $error("standby not left within 60 us");
   AST_RESET_SEQ: assert property ($rose(core_power_on) |-> !core_reset_n)
      else $error("core powered without reset");
   AST_STARTUP: assert property ($rose(core_reset_n) |-> master_src == LPMCC_SRC_MSI && msi_en)
      else $error("restart not on multispeed oscillator");
   // main scenarios reached
   COV_STOP: cover property ($fell(clocks_gated));
   COV_STBY: cover property ($rose(core_reset_n));
   COV_HSE: cover property ($fell(master_src == LPMCC_SRC_HSE));
endmodule : lpmcc_checker
bind lpmcc_top lpmcc_checker #(.GPIO_W(GPIO_W)) i_lpmcc_checker (
   .sys_clk(sys_clk), .external_reset_pin(external_reset_pin), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_ack_o(wb_ack_o), .gpio_line(gpio_line), .external_reset_pin_n(external_reset_pin_n),
   .master_src(master_src), .clocks_gated(clocks_gated), .pll_en(pll_en), .msi_en(msi_en),
   .hsi_en(hsi_en), .hse_en(hse_en), .core_power_on(core_power_on),
   .core_reset_n(core_reset_n), .sys_bus_en(sys_bus_en)
);
`default_nettype wire

// ==== tb/lpmcc_wake_src.sv ====
// wake-source model: event lines and oscillator activity
`default_nettype none
module lpmcc_wake_src (
   input  wire logic        sys_clk,
   input  wire logic        hse_run,
   input  wire logic        lse_run,
   output logic [33:0]      ev,
   output logic             hse_tick,
   output logic             lse_tick
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] ph = 2'h0;
   initial begin
      ev = '0;
      hse_tick = 1'b0;
      lse_tick = 1'b0;
   end
   // a stopped crystal stands still, so the monitors must notice
   always @(posedge sys_clk) begin
      ph <= ph + 2'h1;
      if (hse_run && ph[0])
         hse_tick <= ~hse_tick;
      if (lse_run && ph == 2'h3)
         lse_tick <= ~lse_tick;
   end
   // raise one event line for n cycles
   task automatic fire(input int b, input int n);
      @(posedge sys_clk);
      ev[b] <= 1'b1;
      repeat (n) @(posedge sys_clk);
      ev[b] <= 1'b0;
   endtask : fire
endmodule : lpmcc_wake_src
`default_nettype wire

// ==== tb/tb_low_power_mode_clock_control.sv ====
// self-checking bench of the power/clock controller
`include "lpmcc_map.svh"
`default_nettype none
module tb_low_power_mode_clock_control;
   timeunit 1ns;
   timeprecision 1ps;
   import lpmcc_pkg::*;
`define CHK(nm, ex, gt) begin checks_done++; if ((gt) !== (ex)) begin miscompares++; \
   $display("mismatch %s expected %0h seen %0h", nm, ex, gt); end end
`define WAITC(c, n) begin k = 0; while (!(c) && k < (n)) begin @(negedge sys_clk); k++; end end
   logic        sys_clk = 1'b0;
   logic        external_reset_pin = 1'b0;
   logic        wb_cyc_i = 1'b0;
   logic        wb_stb_i = 1'b0;
   logic        wb_we_i = 1'b0;
   logic [7:0]  wb_adr_i = 8'h00;
   logic [31:0] wb_dat_i = 32'h0;
   logic        vref_on = 1'b0;
   logic        periph_osc_req = 1'b0;
   logic        hse_run = 1'b0;
   logic        lse_run = 1'b1;
   logic [33:0] ev;
   logic [31:0] rd, wb_dat_o;
   logic        wb_ack_o, hse_tick, lse_tick, clocks_gated, pll_en, msi_en, hsi_en, hse_en;
   logic        lse_en, lsi_en, core_power_on, core_reset_n, cpu_wake, irq;
   logic        sys_bus_en, periph1_en, periph2_en;
   logic [1:0]  clock_output_sel;
   lpmcc_src_t  master_src;
   int          k, s, p1, p2, checks_done, miscompares, cyc_cnt;
   int          srcs[5] = '{16, 17, 18, 19, 23};
   // event lines of the far side
   wire logic [15:0] gpio_line = ev[15:0];
   wire logic [1:0]  comp_event = ev[18:17];
   wire logic [4:0]  periph_wake = ev[23:19];
   wire logic [2:0]  wakeup_pin = ev[26:24];
   wire logic [4:0]  rtc_event = ev[31:27];
   always #2 sys_clk = ~sys_clk;
   lpmcc_wake_src i_lpmcc_wake_src (.sys_clk, .hse_run, .lse_run, .ev, .hse_tick, .lse_tick);
   // standby exit shortened to 20 cycles, lse timeout to 32
   lpmcc_top #(.STBY_WAKE_CYC(20), .LSE_TMO(32)) i_lpmcc_top (.sys_clk, .external_reset_pin, .wb_cyc_i,
      .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i(4'hF), .wb_dat_i, .wb_dat_o, .wb_ack_o,
      .gpio_line, .supply_voltage_detector(ev[16]), .comp_event, .vref_on, .periph_wake,
      .periph_osc_req, .external_reset_pin_n(!ev[33]), .watchdog_reset(ev[32]), .wakeup_pin,
      .rtc_event, .hse_tick, .lse_tick, .master_src, .clocks_gated, .pll_en, .msi_en,
      .hsi_en, .hse_en, .lse_en, .lsi_en, .core_power_on, .core_reset_n, .cpu_wake,
      .sys_bus_en, .periph1_en, .periph2_en, .clock_output_sel, .irq);
   // hang guard
   always @(posedge sys_clk) begin
      cyc_cnt++;
      if (cyc_cnt == 20000) begin
         miscompares++;
         final_report();
      end
   end
   task automatic final_report();
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : final_report
   // one classic wishbone cycle; read data lands in rd
   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      // hold until ack is seen at a rising edge; only the hang guard ends the wait
      do @(posedge sys_clk); while (wb_ack_o !== 1'b1);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(negedge sys_clk);
   endtask : wb
   task automatic t_reset();
      @(negedge sys_clk);
      `CHK("src", LPMCC_SRC_MSI, master_src)
      `CHK("msi", 1'b1, msi_en)
      wb(0, `LPMCC_CLK_OFS, 32'h0);
      `CHK("clk reg", 32'h0, rd)
      wb(1, 8'h20, 32'hFFFF_FFFF);
      wb(0, 8'h20, 32'h0);
      `CHK("unmapped", 32'h0, rd)
      $display("t_reset done");
   endtask : t_reset
   task automatic t_clk();
      wb(1, `LPMCC_CLK_OFS, 32'h198);
      `CHK("out sel", 2'h2, clock_output_sel)
      s = 0;
      p1 = 0;
      p2 = 0;
      repeat (40) begin
         @(negedge sys_clk);
         s += sys_bus_en;
         p1 += periph1_en;
         p2 += periph2_en;
      end
      `CHK("sys div", 20, s)
      `CHK("p1 div", 10, p1)
      `CHK("p2 div", 40, p2)
      $display("t_clk done");
   endtask : t_clk
   task automatic t_stop();
      wb(1, `LPMCC_MASK_OFS, 32'h1);
      @(posedge sys_clk);
      periph_osc_req <= 1'b1;
      wb(1, `LPMCC_CTRL_OFS, 32'h1);
      repeat (3) @(negedge sys_clk);
      `CHK("gated", 1'b1, clocks_gated)
      `CHK("osc off", 3'h0, {pll_en, msi_en, hse_en})
      `CHK("hsi kept", 1'b1, hsi_en)
      i_lpmcc_wake_src.fire(3, 4);
      `WAITC(clocks_gated === 1'b0, 875)
      `CHK("woke", 1'b0, clocks_gated)
      `CHK("irq", 1'b1, irq)
      wb(1, `LPMCC_IRQ_OFS, 32'h1);
      `CHK("irq clr", 1'b0, irq)
      @(posedge sys_clk);
      periph_osc_req <= 1'b0;
      vref_on <= 1'b1;
      foreach (srcs[i]) begin
         wb(1, `LPMCC_CTRL_OFS, 32'h1);
         i_lpmcc_wake_src.fire(srcs[i], 4);
         `WAITC(clocks_gated === 1'b0, 875)
         `CHK("source woke", 1'b0, clocks_gated)
      end
      @(posedge sys_clk);
      vref_on <= 1'b0;
      wb(1, `LPMCC_CTRL_OFS, 32'h1);
      i_lpmcc_wake_src.fire(17, 4);
      repeat (10) @(negedge sys_clk);
      `CHK("comp no ref", 1'b1, clocks_gated)
      i_lpmcc_wake_src.fire(0, 4);
      `WAITC(clocks_gated === 1'b0, 875)
      $display("t_stop done");
   endtask : t_stop
   task automatic t_stby(input logic rtc, input int b);
      wb(1, `LPMCC_RETAIN_OFS, 32'hA5);
      wb(1, `LPMCC_CLK_OFS, 32'h8);
      wb(1, `LPMCC_CTRL_OFS, {24'h0, 3'h7, 2'h0, rtc, 2'h2});
      repeat (3) @(negedge sys_clk);
      `CHK("core off", 1'b0, core_power_on)
      `CHK("slow osc", rtc, lse_en | lsi_en)
      if (!rtc) begin
         i_lpmcc_wake_src.fire(27, 4);
         i_lpmcc_wake_src.fire(32, 4);
         repeat (4) @(negedge sys_clk);
         `CHK("no rtc exit", 1'b0, core_power_on)
      end
      i_lpmcc_wake_src.fire(b, 4);
      `WAITC(core_power_on === 1'b1 && core_reset_n === 1'b1, 15000)
      `CHK("exit", 1'b1, core_power_on & core_reset_n)
      `CHK("restart src", LPMCC_SRC_MSI, master_src)
      wb(0, `LPMCC_RETAIN_OFS, 32'h0);
      `CHK("retained", 32'hA5, rd)
      wb(0, `LPMCC_CLK_OFS, 32'h0);
      `CHK("clk lost", 32'h0, rd)
      $display("t_stby done");
   endtask : t_stby
   task automatic t_osc();
      hse_run <= 1'b1;
      wb(1, `LPMCC_MASK_OFS, 32'h2);
      wb(1, `LPMCC_CLK_OFS, 32'h2);
      wb(1, `LPMCC_CTRL_OFS, 32'h8);
      repeat (40) @(negedge sys_clk);
      `CHK("on hse", LPMCC_SRC_HSE, master_src)
      hse_run <= 1'b0;
      `WAITC(master_src === LPMCC_SRC_HSI, 40)
      `CHK("to hsi", LPMCC_SRC_HSI, master_src)
      `CHK("hse irq", 1'b1, irq)
      wb(1, `LPMCC_MASK_OFS, 32'h0);
      wb(1, `LPMCC_CTRL_OFS, 32'h10);
      lse_run <= 1'b0;
      repeat (80) @(negedge sys_clk);
      `CHK("masked", 1'b0, irq)
      wb(0, `LPMCC_IRQ_OFS, 32'h0);
      `CHK("lse flag", 1'b1, rd[`LPMCC_IRQ_LSEFAIL])
      wb(1, `LPMCC_MASK_OFS, 32'h4);
      `CHK("lse irq", 1'b1, irq)
      wb(1, `LPMCC_CTRL_OFS, 32'h0);
      wb(1, `LPMCC_IRQ_OFS, 32'h6);
      `CHK("all clr", 1'b0, irq)
      $display("t_osc done");
   endtask : t_osc
   initial begin
      repeat (5) @(posedge sys_clk);
      external_reset_pin <= 1'b1;
      t_reset();
      t_clk();
      t_stop();
      t_stby(1'b1, 24);
      t_stby(1'b1, 32);
      t_stby(1'b1, 31);
      t_stby(1'b0, 26);
      t_stby(1'b0, 33);
      t_osc();
      final_report();
   end
endmodule : tb_low_power_mode_clock_control
`default_nettype wire
